// *** rtl/reset_mode_entry_and_port_three.sv ***
// Reset pin filter, host/normal mode entry, program store strobe
// generator and third-port pin muxing with alternate functions.
// Assumes a 40 MHz clk from the oscillator; pins are asynchronous.
//
// Functional notes
// - Latch one lets pull-up hold pin high
// - Bit 0 serial in, bit 1 serial out
// - Bits 2,3 are external interrupt inputs
// - Bits 4,5 are counter inputs
// - Bit 6 write strobe, bit 7 read strobe
// - Strobe held high for internal execution
// - Strobe pulses twice per machine cycle externally
// - Data access skips two strobe pulses
// - Reset high two machine cycles resets
// - Strobe fall after 10 cycles enters host
// - No strobe fall gives normal mode
`default_nettype none
module reset_mode_entry_and_port_three
    import reset_mode_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          resetPin,
    input  wire logic                          execExternal,
    input  wire logic                          dataAccess,
    input  wire logic [reset_mode_pkg::PORT_W-1:0] portLatch,
    input  wire logic                          serialTx,
    input  wire logic                          dataWrStrobe_n,
    input  wire logic                          dataRdStrobe_n,
    input  wire logic                          strobePinIn,
    output logic                               program_store_strobe_n,
    output logic                               strobeOe,
    input  wire logic [reset_mode_pkg::PORT_W-1:0] thirdPortIn,
    output logic [reset_mode_pkg::PORT_W-1:0]  thirdPortOut,
    output logic [reset_mode_pkg::PORT_W-1:0]  thirdPortOe,
    output logic [reset_mode_pkg::PORT_W-1:0]  thirdPortSync,
    output logic                               serialRx,
    output logic                               ext_irq_zero_n,
    output logic                               ext_irq_one_n,
    output logic                               counter_zero_input,
    output logic                               counter_one_input,
    output logic                               coreReset,
    output logic                               hostMode
);
    import reset_mode_pkg::*;

    //****************************************************************
    // Pin synchronisers
    //****************************************************************
    logic rstSync;
    logic strobeSync;
    logic [PORT_W-1:0] portSync;

    sync_two_ff u_sync_rst (
        .clk     (clk),
        .arst_n  (arst_n),
        .resetVal(1'b1),
        .pinIn   (resetPin),
        .syncOut (rstSync)
    );
    sync_two_ff u_sync_strobe (
        .clk     (clk),
        .arst_n  (arst_n),
        .resetVal(1'b1),
        .pinIn   (strobePinIn),
        .syncOut (strobeSync)
    );
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_port_sync
            sync_two_ff u_sync_port (
                .clk     (clk),
                .arst_n  (arst_n),
                .resetVal(1'b1),
                .pinIn   (thirdPortIn[gi]),
                .syncOut (portSync[gi])
            );
        end
    endgenerate

    //****************************************************************
    // Machine cycle timing
    //****************************************************************
    logic [MC_CNT_W-1:0] phase_ff;
    logic [MC_CNT_W-1:0] nxt_phase;
    logic                mcTick;

    always_comb begin
        mcTick = (phase_ff == MC_CNT_W'(CLKS_PER_MC - 1));
        nxt_phase = mcTick ? '0 : phase_ff + MC_CNT_W'(1);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    //****************************************************************
    // Reset filter and mode entry
    //****************************************************************
    logic [HOLD_CNT_W-1:0] hold_ff;
    logic [HOLD_CNT_W-1:0] nxt_hold;
    mode_t                 mode_ff;
    mode_t                 nxt_mode;
    logic                  hostReq_ff;
    logic                  nxt_hostReq;
    logic                  strobePrev_ff;
    logic                  nxt_strobePrev;
    logic                  strobeFall;

    always_comb begin
        strobeFall     = strobePrev_ff && !strobeSync;
        nxt_strobePrev = strobeSync;
        nxt_hold       = hold_ff;
        nxt_hostReq    = hostReq_ff;
        nxt_mode       = mode_ff;
        if (!rstSync) begin
            nxt_hold = '0;
        end else if (mcTick && hold_ff != '1) begin
            nxt_hold = hold_ff + HOLD_CNT_W'(1);
        end
        unique case (mode_ff)
            MODE_RUN, MODE_HOST: begin
                // Only a held reset counts; glitches do not reset
                if (rstSync && hold_ff >= HOLD_CNT_W'(RST_HOLD_MC)) begin
                    nxt_mode    = MODE_RESET;
                    nxt_hostReq = 1'b0;
                end
            end
            MODE_RESET: begin
                // Fall only counts once the hold exceeds ten cycles
                if (rstSync && strobeFall
                        && hold_ff > HOLD_CNT_W'(HOST_HOLD_MC)) begin
                    nxt_hostReq = 1'b1;
                end
                if (!rstSync) begin
                    nxt_mode = hostReq_ff ? MODE_HOST : MODE_RUN;
                end
            end
            default: nxt_mode = MODE_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_ff       <= '0;
            mode_ff       <= MODE_RESET;
            hostReq_ff    <= 1'b0;
            strobePrev_ff <= 1'b1;
        end else begin
            hold_ff       <= nxt_hold;
            mode_ff       <= nxt_mode;
            hostReq_ff    <= nxt_hostReq;
            strobePrev_ff <= nxt_strobePrev;
        end
    end

    assign coreReset = (mode_ff == MODE_RESET);
    assign hostMode  = (mode_ff == MODE_HOST);

    //****************************************************************
    // Program store strobe
    //****************************************************************
    logic strobe_ff;
    logic nxt_strobe;
    logic skip_ff;
    logic nxt_skip;
    logic halfPhaseLow;

    always_comb begin
        halfPhaseLow = 1'b0;
        if (phase_ff >= MC_CNT_W'(HALF_MC)) begin
            halfPhaseLow = (phase_ff - MC_CNT_W'(HALF_MC))
                               >= MC_CNT_W'(STROBE_LO_START)
                        && (phase_ff - MC_CNT_W'(HALF_MC))
                               <  MC_CNT_W'(STROBE_LO_END);
        end else begin
            halfPhaseLow = phase_ff >= MC_CNT_W'(STROBE_LO_START)
                        && phase_ff <  MC_CNT_W'(STROBE_LO_END);
        end
        // Skip latched per machine cycle so both pulses drop together
        nxt_skip = skip_ff;
        if (mcTick) begin
            nxt_skip = dataAccess;
        end
        nxt_strobe = 1'b1;
        if (mode_ff == MODE_RUN && execExternal && !skip_ff) begin
            nxt_strobe = !halfPhaseLow;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strobe_ff <= 1'b1;
            skip_ff   <= 1'b0;
        end else begin
            strobe_ff <= nxt_strobe;
            skip_ff   <= nxt_skip;
        end
    end

    // Pin released in reset and host mode so the host can drive it
    assign program_store_strobe_n = strobe_ff;
    assign strobeOe               = (mode_ff == MODE_RUN);

    //****************************************************************
    // Third port
    //****************************************************************
    logic [PORT_W-1:0] portOut_ff;
    logic [PORT_W-1:0] nxt_portOut;
    logic [PORT_W-1:0] altOut;

    always_comb begin
        altOut          = '1;
        altOut[BIT_TXD] = serialTx;
        altOut[BIT_WR]  = dataWrStrobe_n;
        altOut[BIT_RD]  = dataRdStrobe_n;
        // Zero latch forces low; one passes alternate function
        nxt_portOut = portLatch & altOut;
        if (mode_ff != MODE_RUN) begin
            nxt_portOut = PORT_RESET_VAL;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            portOut_ff <= PORT_RESET_VAL;
        end else begin
            portOut_ff <= nxt_portOut;
        end
    end

    // Drive low only; a one leaves the weak pull-up in charge
    assign thirdPortOut = portOut_ff;
    assign thirdPortOe  = ~portOut_ff;

    // Host controls visible here during host mode
    assign thirdPortSync      = portSync;
    assign serialRx           = portSync[BIT_RXD];
    assign ext_irq_zero_n     = portSync[BIT_IRQ0];
    assign ext_irq_one_n      = portSync[BIT_IRQ1];
    assign counter_zero_input = portSync[BIT_CNT0];
    assign counter_one_input  = portSync[BIT_CNT1];

    //****************************************************************
    // Checks
    //****************************************************************
    chk_strobe_internal: assert property (
        @(posedge clk) disable iff (!arst_n)
        (!execExternal && $past(!execExternal)) |-> program_store_strobe_n)
        else $error("strobe active during internal execution");

    // Helper: strobe falls counted over each machine cycle
    logic [1:0] pulseCnt_ff;
    logic [1:0] nxt_pulseCnt;
    logic       cleanMc_ff;
    logic       nxt_cleanMc;
    logic       strobeLast_ff;

    always_comb begin
        nxt_pulseCnt = pulseCnt_ff + 2'(strobeLast_ff && !strobe_ff);
        nxt_cleanMc  = cleanMc_ff && mode_ff == MODE_RUN && execExternal
                    && !skip_ff;
        if (mcTick) begin
            nxt_pulseCnt = '0;
            nxt_cleanMc  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulseCnt_ff   <= '0;
            cleanMc_ff    <= 1'b0;
            strobeLast_ff <= 1'b1;
        end else begin
            pulseCnt_ff   <= nxt_pulseCnt;
            cleanMc_ff    <= nxt_cleanMc;
            strobeLast_ff <= strobe_ff;
        end
    end

    chk_strobe_twice: assert property (
        @(posedge clk) disable iff (!arst_n)
        (mcTick && cleanMc_ff) |-> pulseCnt_ff == 2'h2)
        else $error("strobe pulse count wrong");

    chk_strobe_low: assert property (
        @(posedge clk) disable iff (!arst_n)
        (mode_ff == MODE_RUN && execExternal && !skip_ff
            && $past(execExternal) && $past(mode_ff) == MODE_RUN
            && phase_ff == MC_CNT_W'(2))
        |-> !program_store_strobe_n)
        else $error("strobe not low in pulse window");

    chk_skip_pulses: assert property (
        @(posedge clk) disable iff (!arst_n)
        skip_ff |=> program_store_strobe_n)
        else $error("strobe pulsed during data access");

    chk_reset_entry: assert property (
        @(posedge clk) disable iff (!arst_n)
        (rstSync && hold_ff >= HOLD_CNT_W'(RST_HOLD_MC)
            && mode_ff != MODE_RESET) |=> coreReset)
        else $error("held reset did not reset");

    chk_host_entry: assert property (
        @(posedge clk) disable iff (!arst_n)
        (coreReset && rstSync && strobeFall
            && hold_ff > HOLD_CNT_W'(HOST_HOLD_MC)) |=> hostReq_ff)
        else $error("host request not taken");

    chk_host_release: assert property (
        @(posedge clk) disable iff (!arst_n)
        (coreReset && hostReq_ff && !rstSync) |=> hostMode)
        else $error("host mode not entered");

    chk_normal_entry: assert property (
        @(posedge clk) disable iff (!arst_n)
        (coreReset && !hostReq_ff && !rstSync) |=> !hostMode)
        else $error("host mode without strobe fall");

    chk_latch_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        (mode_ff == MODE_RUN && !portLatch[BIT_WR])
        |=> (thirdPortOe[BIT_WR] && !thirdPortOut[BIT_WR]))
        else $error("zero latch did not drive low");

    chk_pullup_one: assert property (
        @(posedge clk) disable iff (!arst_n)
        (mode_ff == MODE_RUN && portLatch[BIT_CNT0])
        |=> !thirdPortOe[BIT_CNT0])
        else $error("latched one still driven");
endmodule
`default_nettype wire

// *** rtl/reset_mode_pkg.sv ***
// Constants for the reset, mode-entry and third-port pin logic.
// Assumes a 40 MHz core clock; machine cycle = 12 clocks.
`default_nettype none
package reset_mode_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CLKS_PER_MC     = 12;
    localparam int unsigned MC_CNT_W        = 4;
    // Strobe low window inside one half machine cycle (clocks)
    localparam int unsigned STROBE_LO_START = 1;
    localparam int unsigned STROBE_LO_END   = 4;
    localparam int unsigned HALF_MC         = 6;
    localparam int unsigned RST_HOLD_MC     = 2;
    localparam int unsigned HOST_HOLD_MC    = 10;
    localparam int unsigned HOLD_CNT_W      = 5;
    localparam int unsigned PORT_W          = 8;
    localparam logic [7:0]  PORT_RESET_VAL  = 8'hFF;
    // Port bit positions
    localparam int unsigned BIT_RXD         = 0;
    localparam int unsigned BIT_TXD         = 1;
    localparam int unsigned BIT_IRQ0        = 2;
    localparam int unsigned BIT_IRQ1        = 3;
    localparam int unsigned BIT_CNT0        = 4;
    localparam int unsigned BIT_CNT1        = 5;
    localparam int unsigned BIT_WR          = 6;
    localparam int unsigned BIT_RD          = 7;

    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_RESET = 2'b01,
        MODE_HOST  = 2'b10
    } mode_t;
endpackage
`default_nettype wire

// *** rtl/sync_two_ff.sv ***
// Two-flop synchroniser for one asynchronous pin.
// Assumes pin changes slowly relative to clk.
`default_nettype none
module sync_two_ff (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic resetVal,
    input  wire logic pinIn,
    output logic      syncOut
);
    logic stage1_ff;
    logic stage2_ff;
    logic nxt_stage1;
    logic nxt_stage2;

    always_comb begin
        nxt_stage1 = pinIn ^ ~resetVal;
        nxt_stage2 = stage1_ff;
    end

    // Flops hold the pin relative to its reset level, so the reset
    // branch stays constant whatever level the caller asks for.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_ff <= 1'b1;
            stage2_ff <= 1'b1;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign syncOut = stage2_ff ^ ~resetVal;
endmodule
`default_nettype wire

// *** tb/pin_partner_model.sv ***
// Far-side pin model: host programmer on the strobe pin, loads on the
// third port. Assumes the bench sets the host's drive requests.
`default_nettype none
module pin_partner_model (
    input  wire logic       strobeOut,
    input  wire logic       strobeOe,
    input  wire logic       hostLow,
    input  wire logic [7:0] portOut,
    input  wire logic [7:0] portOe,
    input  wire logic [7:0] pullLow,
    output logic            strobePin,
    output logic [7:0]      portPin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Host holds the released strobe high and forces the fall on request
    assign strobePin = strobeOe ? strobeOut : ~hostLow;
    // Pull-up wins unless the port or a load pulls the pin low
    assign portPin = ~((portOe & ~portOut) | pullLow);
endmodule
`default_nettype wire

// *** tb/tb_reset_mode_entry_and_port_three.sv ***
// Self-checking bench for the reset, mode-entry and third-port block.
// Assumes the design files and the pin partner model are compiled first.
`default_nettype none
module tb_reset_mode_entry_and_port_three;
    timeunit 1ns;
    timeprecision 100ps;
    import reset_mode_pkg::*;
    logic       clk = 0, arst_n = 0, resetPin = 0, hostLow = 0;
    logic       execExternal = 0, dataAccess = 0, serialTx = 1;
    logic       dataWrStrobe_n = 1, dataRdStrobe_n = 1;
    logic [7:0] portLatch = 8'hFF, pullLow = 8'h00;
    logic       program_store_strobe_n, strobeOe, strobePin, serialRx;
    logic       ext_irq_zero_n, ext_irq_one_n, coreReset, hostMode;
    logic       counter_zero_input, counter_one_input;
    logic [7:0] thirdPortOut, thirdPortOe, thirdPortSync, thirdPortPin;
    int         n_mismatch = 0;
    int         checks = 0;

    always #12.5 clk = ~clk;

    reset_mode_entry_and_port_three reset_mode_entry_and_port_three_i (
        .clk(clk), .arst_n(arst_n), .resetPin(resetPin),
        .execExternal(execExternal), .dataAccess(dataAccess),
        .portLatch(portLatch), .serialTx(serialTx),
        .dataWrStrobe_n(dataWrStrobe_n), .dataRdStrobe_n(dataRdStrobe_n),
        .strobePinIn(strobePin),
        .program_store_strobe_n(program_store_strobe_n),
        .strobeOe(strobeOe), .thirdPortIn(thirdPortPin),
        .thirdPortOut(thirdPortOut), .thirdPortOe(thirdPortOe),
        .thirdPortSync(thirdPortSync), .serialRx(serialRx),
        .ext_irq_zero_n(ext_irq_zero_n), .ext_irq_one_n(ext_irq_one_n),
        .counter_zero_input(counter_zero_input),
        .counter_one_input(counter_one_input),
        .coreReset(coreReset), .hostMode(hostMode));

    pin_partner_model pin_partner_model_i (
        .strobeOut(program_store_strobe_n), .strobeOe(strobeOe),
        .hostLow(hostLow), .portOut(thirdPortOut), .portOe(thirdPortOe),
        .pullLow(pullLow), .strobePin(strobePin), .portPin(thirdPortPin));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up;
        $display("Mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait on coreReset or hostMode
    task automatic waitFor(input bit host, input logic val, input int bound);
        int i;
        i = 0;
        while ((host ? hostMode : coreReset) !== val) begin
            @(negedge clk);
            i++;
            if (i > bound) begin
                check(8'h00, 8'h01);
                wrap_up();
            end
        end
        checks++;
    endtask

    // Strobe falls over n clocks; data access held 12 clocks from daFrom
    task automatic countFalls(input int n, input int daFrom, output int cnt);
        logic prev;
        cnt = 0;
        prev = program_store_strobe_n;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            dataAccess = (i >= daFrom) && (i < daFrom + 12);
            if (prev === 1'b1 && program_store_strobe_n === 1'b0) cnt++;
            prev = program_store_strobe_n;
        end
        dataAccess = 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic runAfterReset;
        waitFor(0, 1'b0, 20);
        check(8'(hostMode), 8'h00);
        check(8'(strobeOe), 8'h01);
    endtask

    task automatic internalExec;
        int n;
        execExternal = 1'b0;
        countFalls(48, 48, n);
        check(8'(n), 8'h00);
        check(8'(program_store_strobe_n), 8'h01);
    endtask

    // Window lengths are whole half cycles, so the count is exact
    task automatic externalExec;
        int n;
        execExternal = 1'b1;
        countFalls(24, 24, n);
        countFalls(120, 120, n);
        check(8'(n), 8'h14);
        countFalls(120, 24, n);
        check(8'(n), 8'h12);
        execExternal = 1'b0;
    endtask

    task automatic portAlt;
        logic [7:0] latchT[4] = '{8'hFF, 8'hFF, 8'h5A, 8'h00};
        logic [2:0] altT[4] = '{3'b111, 3'b000, 3'b111, 3'b111};
        logic [7:0] pullT[4] = '{8'h00, 8'h3C, 8'hA5, 8'h00};
        logic [7:0] exp, pin;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            portLatch = latchT[i];
            {dataRdStrobe_n, dataWrStrobe_n, serialTx} = altT[i];
            pullLow = pullT[i];
            exp = latchT[i] & {altT[i][2:1], 4'hF, altT[i][0], 1'b1};
            pin = exp & ~pullT[i];
            repeat (2) @(negedge clk);
            check(thirdPortOut, exp);
            check(thirdPortOe, ~exp);
            check(thirdPortPin, pin);
            repeat (3) @(negedge clk);
            check(thirdPortSync, pin);
            check(8'({counter_one_input, counter_zero_input, ext_irq_one_n,
                ext_irq_zero_n, serialRx}), 8'({pin[5:2], pin[0]}));
        end
        pullLow = 8'h00;
    endtask

    task automatic shortResetPin;
        logic seen;
        seen = 1'b0;
        resetPin = 1'b1;
        repeat (6) @(negedge clk);
        resetPin = 1'b0;
        repeat (40) begin
            @(negedge clk);
            if (coreReset !== 1'b0) seen = 1'b1;
        end
        check(8'(seen), 8'h00);
    endtask

    // Strobe falls too early in the reset hold, so no host entry
    task automatic hostRefused;
        resetPin = 1'b1;
        waitFor(0, 1'b1, 48);
        repeat (36) @(negedge clk);
        hostLow = 1'b1;
        repeat (168) @(negedge clk);
        resetPin = 1'b0;
        waitFor(0, 1'b0, 20);
        check(8'(hostMode), 8'h00);
        hostLow = 1'b0;
    endtask

    task automatic hostEntry;
        resetPin = 1'b1;
        waitFor(0, 1'b1, 48);
        repeat (168) @(negedge clk);
        hostLow = 1'b1;
        repeat (4) @(negedge clk);
        resetPin = 1'b0;
        waitFor(1, 1'b1, 20);
        check(8'(coreReset), 8'h00);
        check(8'(strobeOe), 8'h00);
    endtask

    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        runAfterReset();
        internalExec();
        externalExec();
        portAlt();
        shortResetPin();
        hostRefused();
        hostEntry();
        wrap_up();
    end
endmodule
`default_nettype wire
